/* hdl/wdtr_pkg.sv */
/*
  constants, register map and carrier types for the watchdog and
  timer reload block.
  assumes a 100 MHz system clock and a classic wishbone master.
*/
package wdtr_pkg;

  ////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WDOG_BASE_NS  = 62_500_000;
  localparam int unsigned WDOG_BASE_CYC = WDOG_BASE_NS / CLK_PERIOD_NS;
  localparam int unsigned RST_LOW_NS    = 62_500_000;
  localparam int unsigned RST_LOW_CYC   =
    (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_TMR_CTRL   = 6'h18;
  localparam logic [5:0] IDX_TMR_COUNT  = 6'h19;
  localparam logic [5:0] IDX_TMR_RELOAD = 6'h1A;
  localparam logic [5:0] IDX_WDOG_CTRL  = 6'h1B;
  localparam logic [5:0] IDX_STATUS     = 6'h20;
  localparam logic [5:0] IDX_IRQ_EN     = 6'h21;
  localparam logic [5:0] IDX_IRQ_CLR    = 6'h22;

  // field positions
  localparam int unsigned TMR_EN_BIT  = 0;
  localparam int unsigned TMR_RPT_BIT = 1;
  localparam int unsigned ST_TMR_BIT  = 0;
  localparam int unsigned ST_WDOG_BIT = 1;
  localparam int unsigned ST_WIDTH    = 2;

  // reset values
  localparam logic [7:0] TMR_CTRL_RST   = 8'h00;
  localparam logic [7:0] TMR_COUNT_RST  = 8'h00;
  localparam logic [7:0] TMR_RELOAD_RST = 8'h00;
  localparam logic [7:0] WDOG_CTRL_RST  = 8'h00;
  localparam logic [1:0] ST_RST         = 2'h0;

  // watchdog clock divisors over the 16 Hz base, per clock select
  localparam logic [6:0] WD_DIV_16HZ  = 7'h01;
  localparam logic [6:0] WD_DIV_4HZ   = 7'h04;
  localparam logic [6:0] WD_DIV_1HZ   = 7'h10;
  localparam logic [6:0] WD_DIV_QHZ   = 7'h40;

  ////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wdtr_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wdtr_wb_rsp_s;

  typedef struct packed {
    logic       watchdog_steer;
    logic [4:0] watchdog_multiplier;
    logic [1:0] watchdog_clock_select;
  } wdtr_wdog_ctrl_s;

  function automatic logic [6:0] wdtr_div(input logic [1:0] sel);
    logic [6:0] d;
    d = WD_DIV_16HZ;
    unique case (sel)
      2'h0: d = WD_DIV_16HZ;
      2'h1: d = WD_DIV_4HZ;
      2'h2: d = WD_DIV_1HZ;
      2'h3: d = WD_DIV_QHZ;
    endcase
    return d;
  endfunction

endpackage

/* hdl/wdtr_top.sv */
/*
  watchdog with interrupt or reset steering, and countdown timer with
  repeat reload, behind a classic wishbone slave.
  assumes countdown_tick_i is a one-cycle pulse at the timer rate and
  all inputs are synchronous to clk_i.
*/

module wdtr_top #(
  parameter int unsigned P_WDOG_BASE_CYC = wdtr_pkg::WDOG_BASE_CYC,
  parameter int unsigned P_RST_LOW_CYC   = wdtr_pkg::RST_LOW_CYC
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire wdtr_pkg::wdtr_wb_req_s wb_req_i,
  output      wdtr_pkg::wdtr_wb_rsp_s wb_rsp_o,
  input  wire logic                   countdown_tick_i,
  output      logic                   irq_o,
  output      logic                   watchdog_irq_out_o,
  output      logic                   wdog_rst_n_o
);
  import wdtr_pkg::*;

  localparam int BW = $clog2(P_WDOG_BASE_CYC + 1);
  localparam int RW = $clog2(P_RST_LOW_CYC + 1);

  wdtr_wb_rsp_s    rsp_reg;
  logic [7:0]      tmr_ctrl_reg;
  logic [7:0]      tmr_count_reg;
  logic [7:0]      tmr_reload_reg;
  wdtr_wdog_ctrl_s wdog_ctrl_reg;
  logic [ST_WIDTH-1:0] status_reg;
  logic [ST_WIDTH-1:0] status_next;
  logic [ST_WIDTH-1:0] irq_en_reg;
  logic [BW-1:0]   base_cnt_reg;
  logic [6:0]      sub_cnt_reg;
  logic [4:0]      wd_cnt_reg;
  logic [RW-1:0]   rst_cnt_reg;
  logic            irq_reg;
  logic            watchdog_irq_out_reg;
  logic            rst_n_reg;

  logic            bus_hit;
  logic            bus_wr;
  logic [5:0]      bus_idx;
  logic [31:0]     rd_data;
  logic            base_tick;
  logic            wd_tick;
  logic            wd_load;
  logic            wd_timeout;
  logic            tmr_zero_evt;
  logic [ST_WIDTH-1:0] st_set;
  logic [ST_WIDTH-1:0] st_clr;

  ////////////////////////////////////////////////////////////////////
  // wishbone slave: answers one cycle after the request, every address.
  // a write lands at the edge where the master samples ack, not before.

  assign bus_hit = wb_req_i.cyc & wb_req_i.stb & ~rsp_reg.ack;
  assign bus_wr  = wb_req_i.cyc & wb_req_i.stb & rsp_reg.ack
                   & wb_req_i.we & wb_req_i.sel[0];
  assign bus_idx = wb_req_i.adr[7:2];

  always_comb begin
    rd_data = 32'h0;
    unique case (bus_idx)
      IDX_TMR_CTRL:   rd_data = {24'h0, tmr_ctrl_reg};
      IDX_TMR_COUNT:  rd_data = {24'h0, tmr_count_reg};
      IDX_TMR_RELOAD: rd_data = {24'h0, tmr_reload_reg};
      IDX_WDOG_CTRL:  rd_data = {24'h0, wdog_ctrl_reg};
      IDX_STATUS:     rd_data = {30'h0, status_reg};
      IDX_IRQ_EN:     rd_data = {30'h0, irq_en_reg};
      default:        rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.ack <= bus_hit;
      rsp_reg.dat <= bus_hit ? rd_data : 32'h0;
    end
  end

  assign wb_rsp_o = rsp_reg;

  ////////////////////////////////////////////////////////////////////
  // software-written registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_reload_reg <= TMR_RELOAD_RST;
      irq_en_reg     <= ST_RST;
    end else if (bus_wr) begin
      if (bus_idx == IDX_TMR_RELOAD) begin
        tmr_reload_reg <= wb_req_i.dat[7:0];
      end
      if (bus_idx == IDX_IRQ_EN) begin
        irq_en_reg <= wb_req_i.dat[ST_WIDTH-1:0];
      end
    end
  end

  assign wd_load = bus_wr & (bus_idx == IDX_WDOG_CTRL);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdog_ctrl_reg <= WDOG_CTRL_RST;
    end else if (wd_load) begin
      wdog_ctrl_reg <= wb_req_i.dat[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // countdown timer; a single-mode run simply parks at zero

  // a zero reload in repeat mode reaches zero on every tick
  assign tmr_zero_evt = countdown_tick_i & tmr_ctrl_reg[TMR_EN_BIT]
                        & ((tmr_count_reg == 8'h01)
                           | ((tmr_count_reg == 8'h00)
                              & tmr_ctrl_reg[TMR_RPT_BIT]
                              & (tmr_reload_reg == 8'h00)));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_ctrl_reg  <= TMR_CTRL_RST;
      tmr_count_reg <= TMR_COUNT_RST;
    end else begin
      if (bus_wr && bus_idx == IDX_TMR_CTRL) begin
        tmr_ctrl_reg <= wb_req_i.dat[7:0];
      end
      if (bus_wr && bus_idx == IDX_TMR_COUNT) begin
        tmr_count_reg <= wb_req_i.dat[7:0];
      end else if (countdown_tick_i && tmr_ctrl_reg[TMR_EN_BIT]) begin
        if (tmr_count_reg != 8'h00) begin
          tmr_count_reg <= tmr_count_reg - 8'h01;
        end else if (tmr_ctrl_reg[TMR_RPT_BIT]) begin
          tmr_count_reg <= tmr_reload_reg;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // watchdog clock: 16 Hz base, then divided per clock select.
  // a control write restarts both so the timeout is exact.

  assign base_tick = (base_cnt_reg == BW'(P_WDOG_BASE_CYC - 1));
  assign wd_tick   = base_tick &&
    (sub_cnt_reg == wdtr_div(wdog_ctrl_reg.watchdog_clock_select)
                    - 7'h01);

  always_ff @(posedge clk_i) begin
    if (rst_i || wd_load || base_tick) begin
      base_cnt_reg <= '0;
    end else begin
      base_cnt_reg <= base_cnt_reg + BW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || wd_load || wd_tick) begin
      sub_cnt_reg <= 7'h00;
    end else if (base_tick) begin
      sub_cnt_reg <= sub_cnt_reg + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // watchdog count; stops at zero until software rewrites control

  assign wd_timeout = wd_tick & (wd_cnt_reg == 5'h01);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_cnt_reg <= 5'h00;
    end else if (wd_load) begin
      // zero multiplier loads zero, which never times out
      wd_cnt_reg <= wb_req_i.dat[6:2];
    end else if (wd_tick && wd_cnt_reg != 5'h00) begin
      wd_cnt_reg <= wd_cnt_reg - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reset steering: low the cycle after timeout, held a fixed time

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_n_reg   <= 1'b1;
      rst_cnt_reg <= '0;
    end else if (wd_timeout && wdog_ctrl_reg.watchdog_steer) begin
      rst_n_reg   <= 1'b0;
      rst_cnt_reg <= RW'(P_RST_LOW_CYC - 1);
    end else if (!rst_n_reg) begin
      if (rst_cnt_reg == '0) begin
        rst_n_reg <= 1'b1;
      end else begin
        rst_cnt_reg <= rst_cnt_reg - RW'(1);
      end
    end
  end

  assign wdog_rst_n_o = rst_n_reg;

  ////////////////////////////////////////////////////////////////////
  // sticky status; a set in the clearing cycle wins

  always_comb begin
    st_set = '0;
    st_clr = '0;
    st_set[ST_TMR_BIT]  = tmr_zero_evt;
    st_set[ST_WDOG_BIT] = wd_timeout &
                          ~wdog_ctrl_reg.watchdog_steer;
    if (bus_wr && bus_idx == IDX_IRQ_CLR) begin
      st_clr = wb_req_i.dat[ST_WIDTH-1:0];
    end
    status_next = (status_reg & ~st_clr) | st_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= ST_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg  <= 1'b0;
      watchdog_irq_out_reg <= 1'b0;
    end else begin
      irq_reg  <= |(status_next & irq_en_reg);
      // the watchdog line follows its flag, independent of the mask
      watchdog_irq_out_reg <= status_next[ST_WDOG_BIT];
    end
  end

  assign irq_o              = irq_reg;
  assign watchdog_irq_out_o = watchdog_irq_out_reg;

  ////////////////////////////////////////////////////////////////////
  // checks

  // cycles since the last watchdog clock, kept only for the rate check
  logic [31:0] wd_gap_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i || wd_load || wd_tick) begin
      wd_gap_reg <= 32'h0;
    end else begin
      wd_gap_reg <= wd_gap_reg + 32'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_repeat_reload: assert property (
    countdown_tick_i && tmr_ctrl_reg[TMR_EN_BIT] && !bus_wr &&
    tmr_count_reg == 8'h00 && tmr_ctrl_reg[TMR_RPT_BIT]
    |=> tmr_count_reg == $past(tmr_reload_reg))
    else $error("countdown did not reload");

  chk_zero_event: assert property (
    tmr_zero_evt && !bus_wr |=> tmr_count_reg == 8'h00 &&
    status_reg[ST_TMR_BIT])
    else $error("timer zero not flagged");

  chk_wdog_flag: assert property (
    wd_timeout && !wdog_ctrl_reg.watchdog_steer
    |=> status_reg[ST_WDOG_BIT] && watchdog_irq_out_o && wdog_rst_n_o)
    else $error("watchdog flag or line missing");

  chk_steer_noflag: assert property (
    wd_timeout && wdog_ctrl_reg.watchdog_steer &&
    !status_reg[ST_WDOG_BIT] |=> !status_reg[ST_WDOG_BIT])
    else $error("flag set in reset steering");

  chk_reset_low: assert property (
    wd_timeout && wdog_ctrl_reg.watchdog_steer
    |=> !wdog_rst_n_o && rst_cnt_reg == RW'(P_RST_LOW_CYC - 1))
    else $error("reset not asserted on timeout");

  chk_reset_rise: assert property (
    $rose(wdog_rst_n_o) |-> $past(rst_cnt_reg) == '0)
    else $error("reset released early");

  chk_wdog_off: assert property (
    wdog_ctrl_reg.watchdog_multiplier == 5'h00 && !wd_load
    |-> !wd_timeout ##1 wd_cnt_reg == 5'h00)
    else $error("disabled watchdog counting");

  chk_wdog_load: assert property (
    wd_load |=> wd_cnt_reg == wdog_ctrl_reg.watchdog_multiplier &&
    base_cnt_reg == '0 && sub_cnt_reg == 7'h00)
    else $error("watchdog restart failed");

  chk_clock_rate: assert property (
    wd_tick |-> wd_gap_reg + 32'h1 ==
      32'(wdtr_div(wdog_ctrl_reg.watchdog_clock_select))
      * P_WDOG_BASE_CYC)
    else $error("watchdog clock off rate");

  chk_bus_ack: assert property (
    bus_hit |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
    else $error("bus answer not one cycle");

  chk_irq_level: assert property (
    irq_o == |(status_reg & $past(irq_en_reg)))
    else $error("interrupt line disagrees with status");

  chk_watchdog_irq_out_follow: assert property (
    watchdog_irq_out_o == status_reg[ST_WDOG_BIT])
    else $error("watchdog line not following flag");

  chk_reset_cause: assert property (
    $fell(wdog_rst_n_o)
    |-> $past(wd_timeout) && $past(wdog_ctrl_reg.watchdog_steer))
    else $error("reset pulled low without timeout");

  chk_reset_hold: assert property (
    !wdog_rst_n_o && rst_cnt_reg != '0 |=> !wdog_rst_n_o)
    else $error("reset released before its count ran out");

  chk_count_park: assert property (
    countdown_tick_i && tmr_ctrl_reg[TMR_EN_BIT] && !bus_wr &&
    !tmr_ctrl_reg[TMR_RPT_BIT] && tmr_count_reg == 8'h00
    |=> tmr_count_reg == 8'h00)
    else $error("single-mode countdown left zero");

  chk_wdog_stop: assert property (
    wd_timeout && !wd_load |=> wd_cnt_reg == 5'h00)
    else $error("watchdog count did not stop at zero");

endmodule

/* verification/wdtr_host_model.sv */
/*
  host side model: sits behind the watchdog reset pin and measures
  how long it is held in reset.
  assumes the pin is registered on clk_i.
*/
module wdtr_host_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wdog_rst_n_i,
  output      logic [31:0] low_len_o,
  output      logic        low_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cnt;
  // length is reported only on release, so a stuck pin shows nothing
  always @(posedge clk_i) begin
    low_done_o <= 1'h0;
    if (rst_i) begin
      cnt <= 32'h0;
    end else if (wdog_rst_n_i === 1'h0) begin
      cnt <= cnt + 32'h1;
    end else if (cnt != 32'h0) begin
      low_len_o  <= cnt;
      low_done_o <= 1'h1;
      cnt        <= 32'h0;
    end
  end
endmodule

/* verification/tb_wdtr_top.sv */
/*
  self-checking bench for the watchdog and timer reload block.
  assumes wdtr_pkg and wdtr_host_model are compiled first.
*/
module tb_wdtr_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wdtr_pkg::*;
  localparam int BC = 8;
  localparam int RL = 5;
  localparam int DV[4] = '{1, 4, 16, 64};
  logic         clk_i;
  logic         rst_i;
  logic         tick;
  wdtr_wb_req_s req;
  wdtr_wb_rsp_s rsp;
  logic         irq;
  logic         watchdog_irq_out;
  logic         rst_n;
  logic         ldone;
  logic [31:0]  llen;
  logic [31:0]  rq[$], lq[$];
  logic [7:0]   r, c;
  int           n_fail;
  int           checks_done;
  int           m;

  wdtr_top #(.P_WDOG_BASE_CYC(BC), .P_RST_LOW_CYC(RL)) i_wdtr_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .countdown_tick_i(tick), .irq_o(irq), .watchdog_irq_out_o(watchdog_irq_out),
    .wdog_rst_n_o(rst_n));
  wdtr_host_model i_wdtr_host_model (.clk_i(clk_i), .rst_i(rst_i),
    .wdog_rst_n_i(rst_n), .low_len_o(llen), .low_done_o(ldone));

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic timeout;
    n_fail++;
    report_and_stop();
  endtask
  task automatic cmp_val(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_pin(input string nm, input logic e, input logic g);
    cmp_val(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // entered just after an edge; leaves cyc low for one cycle
  task automatic wb(input logic w, input logic [5:0] i,
                    input logic [7:0] d);
    int n;
    req <= '{1'h1, 1'h1, w, {i, 2'h0}, 4'hF, {24'h0, d}};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 20) timeout();
    end while (rsp.ack !== 1'h1);
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    rq.push_back({24'h0, e});
    wb(1'h0, i, 8'h00);
  endtask
  task automatic pulse;
    tick <= 1'h1;
    @(posedge clk_i);
    tick <= 1'h0;
    @(posedge clk_i);
  endtask

  // result watcher: oldest expectation against each read answer
  always @(posedge clk_i) begin
    if (rsp.ack === 1'h1 && req.cyc === 1'h1 && req.we === 1'h0)
      cmp_val("read data", rq.pop_front(), rsp.dat);
    if (ldone === 1'h1)
      cmp_val("reset low cycles", lq.pop_front(), llen);
  end

  //////////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    tick = 1'h0;
    rst_i = 1'h1;
    n_fail = 0;
    checks_done = 0;
    void'($urandom(32'hbe91));
    cyc(2);
    rst_i <= 1'h0;
    cyc(1);
    rd(IDX_TMR_RELOAD, TMR_RELOAD_RST);
    rd(IDX_WDOG_CTRL, WDOG_CTRL_RST);
    wb(1'h1, 6'h3F, 8'hFF);
    rd(6'h3F, 8'h00);
    r = 8'($urandom_range(5, 1));
    wb(1'h1, IDX_TMR_RELOAD, r);
    rd(IDX_TMR_RELOAD, r);
    wb(1'h1, IDX_TMR_COUNT, r);
    wb(1'h1, IDX_IRQ_EN, 8'h03);
    wb(1'h1, IDX_TMR_CTRL, 8'h03);
    c = r;
    for (int k = 0; k < 2 * r + 2; k++) begin
      pulse();
      c = (c == 8'h00) ? r : c - 8'h01;
      rd(IDX_TMR_COUNT, c);
    end
    cmp_pin("irq", 1'h1, irq);
    wb(1'h1, IDX_IRQ_EN, 8'h00);
    cyc(2);
    cmp_pin("masked irq", 1'h0, irq);
    rd(IDX_STATUS, 8'h01);
    wb(1'h1, IDX_IRQ_CLR, 8'h01);
    rd(IDX_STATUS, 8'h00);
    wb(1'h1, IDX_TMR_CTRL, 8'h01);
    wb(1'h1, IDX_TMR_COUNT, 8'h01);
    repeat (2) pulse();
    rd(IDX_TMR_COUNT, 8'h00);
    rd(IDX_STATUS, 8'h01);
    wb(1'h1, IDX_IRQ_CLR, 8'h01);
    wb(1'h1, IDX_TMR_CTRL, 8'h00);
    // steer set but multiplier zero: nothing may ever fire
    wb(1'h1, IDX_WDOG_CTRL, 8'h83);
    cyc(600);
    cmp_pin("reset pin", 1'h1, rst_n);
    rd(IDX_STATUS, 8'h00);
    wb(1'h1, IDX_IRQ_EN, 8'h02);
    for (int s = 0; s < 4; s++) begin
      m = (s == 3) ? 1 : int'($urandom_range(3, 1));
      wb(1'h1, IDX_WDOG_CTRL, {1'h0, 5'(m), 2'(s)});
      cyc(m * BC * DV[s] - 3);
      cmp_pin("early flag", 1'h0, watchdog_irq_out);
      cyc(5);
      cmp_pin("timeout flag", 1'h1, watchdog_irq_out);
      cmp_pin("irq", 1'h1, irq);
      rd(IDX_STATUS, 8'h02);
      wb(1'h1, IDX_WDOG_CTRL, 8'h00);
      wb(1'h1, IDX_IRQ_CLR, 8'h02);
    end
    wb(1'h1, IDX_WDOG_CTRL, 8'h08);
    cyc(10);
    wb(1'h1, IDX_WDOG_CTRL, 8'h08);
    cyc(8);
    cmp_pin("restarted flag", 1'h0, watchdog_irq_out);
    wb(1'h1, IDX_WDOG_CTRL, 8'h00);
    lq.push_back(RL);
    wb(1'h1, IDX_WDOG_CTRL, 8'h84);
    cyc(5);
    cmp_pin("early reset", 1'h1, rst_n);
    cyc(3);
    cmp_pin("reset pin", 1'h0, rst_n);
    cyc(10);
    rd(IDX_STATUS, 8'h00);
    wb(1'h1, IDX_WDOG_CTRL, 8'h00);
    // second reset in mid-run returns the registers to zero
    rst_i <= 1'h1;
    cyc(2);
    rst_i <= 1'h0;
    cyc(1);
    rd(IDX_TMR_RELOAD, TMR_RELOAD_RST);
    cmp_val("pending notes", 32'h0, 32'(rq.size() + lq.size()));
    report_and_stop();
  end
endmodule
